// File: rtl/vcsr_rail.sv
// One rail: synchroniser, code capture and setpoint calculation
`timescale 1ns/10ps
`include "vcsr_defines.svh"
module vcsr_rail
    import vcsr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Configuration
    input wire logic [1:0] fmt,
    input wire vcsr_mv_t lo_mv,
    input wire vcsr_mv_t hi_mv,
    input wire vcsr_code_t boot_code,
    input wire logic cfg_load,
    input wire logic poll_tick,
    // Eight-bit write for this rail
    input wire logic wr8,
    input wire vcsr_code_t wr8_code,
    // Raw pins
    input wire logic [3:0] pins,
    // Result
    output vcsr_mv_t setpoint,
    output logic slew_start
);
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] prev;
    logic [3:0] cand;
    logic [31:0] stab_cnt;
    logic cand_busy;
    logic [2:0] low_bits;
    vcsr_code_t code;
    logic apply_req;
    logic [31:0] calc_cnt;
    logic calc_busy;
    vcsr_mv_t next_setpoint;
    logic [7:0] full_scale;

    // Two stages before anything looks at the pins
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            prev <= 4'h0;
        end else begin
            sync1 <= pins;
            sync2 <= sync1;
            prev <= sync2;
        end
    end

    // Four-bit polling with stability confirm; six-bit strobe capture
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cand <= 4'h0;
            cand_busy <= 1'b0;
            stab_cnt <= 32'h0;
            low_bits <= 3'h0;
            code <= 8'h0;
            apply_req <= 1'b0;
        end else begin
            apply_req <= 1'b0;
            if (cfg_load) begin
                code <= boot_code;
                apply_req <= 1'b1;
                cand_busy <= 1'b0;
            end else if (fmt == `VCSR_FMT_4) begin
                if (cand_busy && sync2 != cand) begin
                    cand_busy <= 1'b0;
                end else if (cand_busy) begin
                    if (stab_cnt >= `VCSR_STABLE_CYC) begin
                        cand_busy <= 1'b0;
                        code <= {4'h0, cand};
                        apply_req <= 1'b1;
                    end else begin
                        stab_cnt <= stab_cnt + 32'h1;
                    end
                end else if (poll_tick && sync2 != code[3:0]) begin
                    cand <= sync2;
                    cand_busy <= 1'b1;
                    stab_cnt <= 32'h0;
                end
            end else if (fmt == `VCSR_FMT_6) begin
                if (prev[3] && !sync2[3]) begin
                    low_bits <= sync2[2:0];
                end
                if (!prev[3] && sync2[3]) begin
                    code <= {2'h0, sync2[2:0], low_bits};
                    apply_req <= 1'b1;
                end
            end else if (wr8) begin
                code <= wr8_code;
                apply_req <= 1'b1;
            end
        end
    end

    // Full scale is two to the width, less one
    always_comb begin
        case (fmt)
            `VCSR_FMT_4: full_scale = 8'((16'h1 << `VCSR_W4) - 16'h1);
            `VCSR_FMT_6: full_scale = 8'((16'h1 << `VCSR_W6) - 16'h1);
            default: full_scale = 8'((16'h1 << `VCSR_W8) - 16'h1);
        endcase
        next_setpoint = 16'((32'(code) * 32'(hi_mv - lo_mv)) / 32'(full_scale)) + lo_mv;
    end

    // Fixed latency mimics the setpoint calculation time
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            calc_busy <= 1'b0;
            calc_cnt <= 32'h0;
            setpoint <= 16'h0;
            slew_start <= 1'b0;
        end else begin
            slew_start <= 1'b0;
            if (apply_req) begin
                calc_busy <= 1'b1;
                calc_cnt <= 32'h0;
            end else if (calc_busy) begin
                if (calc_cnt >= `VCSR_CALC_CYC - 1) begin
                    calc_busy <= 1'b0;
                    setpoint <= next_setpoint;
                    slew_start <= 1'b1;
                end else begin
                    calc_cnt <= calc_cnt + 32'h1;
                end
            end
        end
    end
endmodule : vcsr_rail

// File: rtl/vcsr_defines.svh
// Constants for the voltage code setpoint receiver
`ifndef VCSR_DEFINES_SVH
`define VCSR_DEFINES_SVH
`define VCSR_CLK_MHZ 125
`define VCSR_POLL_US 400
`define VCSR_POLL_CYC (`VCSR_POLL_US * `VCSR_CLK_MHZ)
`define VCSR_STABLE_US 500
`define VCSR_STABLE_CYC (`VCSR_STABLE_US * `VCSR_CLK_MHZ)
`define VCSR_CALC_US 35
`define VCSR_CALC_CYC (`VCSR_CALC_US * `VCSR_CLK_MHZ)
`define VCSR_HOLD_US 125
`define VCSR_HOLD_CYC (`VCSR_HOLD_US * `VCSR_CLK_MHZ)
`define VCSR_CMD_SETUP 8'hbb
`define VCSR_CMD_RAIL1 8'hbc
`define VCSR_CMD_RAIL2 8'hbd
`define VCSR_FMT_4 2'h0
`define VCSR_FMT_6 2'h1
`define VCSR_FMT_8 2'h2
`define VCSR_W4 4'h4
`define VCSR_W6 4'h6
`define VCSR_W8 4'h8
`define VCSR_IDLE_LINES 4'h8
`define VCSR_POLL_W 32
`endif

// File: rtl/vcsr_pkg.sv
// Types for the voltage code setpoint receiver
package vcsr_pkg;
    typedef logic [7:0] vcsr_code_t;
    typedef logic [15:0] vcsr_mv_t;
    typedef enum logic [1:0] {
        VCSR_IDLE = 2'b00,
        VCSR_LOW = 2'b01,
        VCSR_HIGH = 2'b11,
        VCSR_WAIT = 2'b10
    } vcsr_host_e;
endpackage : vcsr_pkg

// File: rtl/vcsr_link_if.sv
// Code lines and command port joining host and receiver
`timescale 1ns/10ps
interface vcsr_link_if;
    logic [1:0] line_a;
    logic [1:0] line_b;
    logic [1:0] line_c;
    logic [1:0] select_strobe;
    logic cmd_valid;
    logic [7:0] cmd_code;
    logic [39:0] cmd_data;
    modport host (output line_a, line_b, line_c, select_strobe, cmd_valid, cmd_code, cmd_data);
    modport device (input line_a, line_b, line_c, select_strobe, cmd_valid, cmd_code, cmd_data);
endinterface : vcsr_link_if

// File: rtl/vcsr_device.sv
// Receiver end: command decode and two rails
`timescale 1ns/10ps
`include "vcsr_defines.svh"
module vcsr_device
    import vcsr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Link
    vcsr_link_if.device link,
    // Setpoints
    output vcsr_mv_t rail1_setpoint,
    output vcsr_mv_t rail2_setpoint,
    output logic rail1_slew_start,
    output logic rail2_slew_start,
    output logic [1:0] code_width_setting
);
    logic [31:0] poll_cnt;
    logic poll_tick;
    logic cfg_load;
    logic boot_pend;
    vcsr_mv_t code_lower_limit;
    vcsr_mv_t code_upper_limit;
    vcsr_code_t boot_code;
    logic [1:0] wr8;
    vcsr_code_t wr8_code;
    vcsr_mv_t sp [2];
    logic [1:0] ss;
    logic [3:0] pins [2];

    // Poll enable divider
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            poll_cnt <= 32'h0;
            poll_tick <= 1'b0;
        end else begin
            poll_tick <= (poll_cnt == `VCSR_POLL_CYC - 1);
            poll_cnt <= (poll_cnt == `VCSR_POLL_CYC - 1) ? 32'h0 : poll_cnt + 32'h1;
        end
    end

    // Command decode; same-clock logic so no synchroniser
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            code_width_setting <= `VCSR_FMT_4;
            code_lower_limit <= 16'h0;
            code_upper_limit <= 16'h0;
            boot_code <= 8'h0;
            boot_pend <= 1'b1;
            cfg_load <= 1'b0;
            wr8 <= 2'h0;
            wr8_code <= 8'h0;
        end else begin
            cfg_load <= boot_pend;
            boot_pend <= 1'b0;
            wr8 <= 2'h0;
            if (link.cmd_valid && link.cmd_code == `VCSR_CMD_SETUP) begin
                code_width_setting <= link.cmd_data[1:0];
                code_lower_limit <= link.cmd_data[23:8];
                code_upper_limit <= link.cmd_data[39:24];
                // Boot code shares the low byte with the width field
                boot_code <= link.cmd_data[7:0];
                boot_pend <= 1'b1;
            end
            if (link.cmd_valid && link.cmd_code == `VCSR_CMD_RAIL1) begin
                wr8 <= 2'b01;
                wr8_code <= link.cmd_data[7:0];
            end
            if (link.cmd_valid && link.cmd_code == `VCSR_CMD_RAIL2) begin
                wr8 <= 2'b10;
                wr8_code <= link.cmd_data[7:0];
            end
        end
    end

    assign pins[0] = {link.select_strobe[0], link.line_c[0], link.line_b[0], link.line_a[0]};
    assign pins[1] = {link.select_strobe[1], link.line_c[1], link.line_b[1], link.line_a[1]};

    // One independent rail per pin group
    genvar r;
    generate
        for (r = 0; r < 2; r++) begin : g_rail
            vcsr_rail u_rail (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .fmt(code_width_setting),
                .lo_mv(code_lower_limit),
                .hi_mv(code_upper_limit),
                .boot_code(boot_code),
                .cfg_load(cfg_load),
                .poll_tick(poll_tick),
                .wr8(wr8[r]),
                .wr8_code(wr8_code),
                .pins(pins[r]),
                .setpoint(sp[r]),
                .slew_start(ss[r])
            );
        end
    endgenerate

    // Outputs already registered inside each rail
    assign rail1_setpoint = sp[0];
    assign rail2_setpoint = sp[1];
    assign rail1_slew_start = ss[0];
    assign rail2_slew_start = ss[1];
endmodule : vcsr_device

// File: rtl/vcsr_host.sv
// Host end: drives code lines and setup or rail commands
`timescale 1ns/10ps
`include "vcsr_defines.svh"
module vcsr_host
    import vcsr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // User request
    input wire logic req_valid,
    input wire logic req_rail,
    input wire vcsr_code_t req_code,
    input wire logic [1:0] req_fmt,
    input wire logic cfg_valid,
    input wire logic [39:0] cfg_data,
    output logic req_ready,
    // Link
    vcsr_link_if.host link
);
    vcsr_host_e state;
    logic [31:0] hold_cnt;
    logic rail;
    vcsr_code_t code;
    logic [3:0] lines [2];
    vcsr_code_t last [2];
    logic cv;
    logic [7:0] cc;
    logic [39:0] cd;

    // Six-bit strobing with 125 us holds
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= VCSR_IDLE;
            hold_cnt <= 32'h0;
            rail <= 1'b0;
            code <= 8'h0;
            lines[0] <= `VCSR_IDLE_LINES;
            lines[1] <= `VCSR_IDLE_LINES;
            last[0] <= 8'h0;
            last[1] <= 8'h0;
            req_ready <= 1'b0;
            cv <= 1'b0;
            cc <= 8'h0;
            cd <= 40'h0;
        end else begin
            cv <= 1'b0;
            req_ready <= (state == VCSR_IDLE) && !req_valid && !cfg_valid;
            case (state)
                VCSR_IDLE: begin
                    if (cfg_valid) begin
                        cv <= 1'b1;
                        cc <= `VCSR_CMD_SETUP;
                        cd <= cfg_data;
                    end else if (req_valid && req_code != last[req_rail]) begin
                        rail <= req_rail;
                        code <= req_code;
                        last[req_rail] <= req_code;
                        if (req_fmt == `VCSR_FMT_8) begin
                            cv <= 1'b1;
                            cc <= req_rail ? `VCSR_CMD_RAIL2 : `VCSR_CMD_RAIL1;
                            cd <= {32'h0, req_code};
                        end else if (req_fmt == `VCSR_FMT_4) begin
                            lines[req_rail] <= req_code[3:0];
                        end else begin
                            lines[req_rail] <= {1'b0, req_code[2:0]};
                            hold_cnt <= 32'h0;
                            state <= VCSR_LOW;
                        end
                    end
                end
                VCSR_LOW: begin
                    if (hold_cnt >= `VCSR_HOLD_CYC) begin
                        lines[rail] <= {1'b1, code[5:3]};
                        hold_cnt <= 32'h0;
                        state <= VCSR_HIGH;
                    end else begin
                        hold_cnt <= hold_cnt + 32'h1;
                    end
                end
                VCSR_HIGH: begin
                    if (hold_cnt >= `VCSR_HOLD_CYC) begin
                        state <= VCSR_IDLE;
                    end else begin
                        hold_cnt <= hold_cnt + 32'h1;
                    end
                end
                default: state <= VCSR_IDLE;
            endcase
        end
    end

    // Lines driven straight from flops
    genvar r;
    generate
        for (r = 0; r < 2; r++) begin : g_pin
            assign link.line_a[r] = lines[r][0];
            assign link.line_b[r] = lines[r][1];
            assign link.line_c[r] = lines[r][2];
            assign link.select_strobe[r] = lines[r][3];
        end
    endgenerate
    assign link.cmd_valid = cv;
    assign link.cmd_code = cc;
    assign link.cmd_data = cd;
endmodule : vcsr_host

// File: verification/vcsr_asserts.sv
// Concurrent checks on the code link and the receiver outputs
`timescale 1ns/10ps
module vcsr_asserts
    import vcsr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Link
    input wire logic [1:0] line_a,
    input wire logic [1:0] line_b,
    input wire logic [1:0] line_c,
    input wire logic [1:0] select_strobe,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    // Receiver outputs
    input wire vcsr_mv_t rail1_setpoint,
    input wire vcsr_mv_t rail2_setpoint,
    input wire logic rail1_slew_start,
    input wire logic rail2_slew_start,
    input wire logic [1:0] code_width_setting
);
    localparam int HOLD_MIN = 8750;
    localparam int CALC_MIN = 4375;
    localparam int CALC_MAX = 16875;
    // Two synchroniser stages and the edge register come before the calculation
    localparam int SYNC_MIN = 4378;
    logic [3:0] lines_now;
    logic [3:0] lines_prev;
    logic lines_moved;
    logic rise6;
    logic [15:0] hold_cnt;
    logic calc_armed;
    logic [15:0] calc_cnt;
    logic slew6;
    assign lines_now = {select_strobe[0], line_c[0], line_b[0], line_a[0]};
    assign lines_moved = lines_now != lines_prev;
    assign slew6 = rail1_slew_start && calc_armed;
    assign rise6 = lines_now[3] && !lines_prev[3] && code_width_setting == 2'h1;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge clk_sys) begin
        lines_prev <= lines_now;
    end
    // Saturates so a quiet link never looks like a short hold
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hold_cnt <= 16'hffff;
        end else if (lines_moved) begin
            hold_cnt <= 16'h0000;
        end else if (hold_cnt != 16'hffff) begin
            hold_cnt <= hold_cnt + 16'h0001;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n || rail1_slew_start) begin
            calc_armed <= 1'b0;
        end else if (rise6) begin
            calc_armed <= 1'b1;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n || rise6) begin
            calc_cnt <= 16'h0001;
        end else if (calc_armed && calc_cnt != 16'hffff) begin
            calc_cnt <= calc_cnt + 16'h0001;
        end
    end
    chk_width_legal: assert property (code_width_setting != 2'h3)
        else $error("width setting undefined");
    chk_cmd_known: assert property (cmd_valid |-> cmd_code inside {8'hbb, 8'hbc, 8'hbd})
        else $error("unknown command code");
    chk_hold_min: assert property (lines_moved |-> hold_cnt >= HOLD_MIN)
        else $error("code lines held too briefly");
    chk_calc_early: assert property (rail1_slew_start && calc_armed |-> calc_cnt >= CALC_MIN)
        else $error("slew started too early");
    chk_calc_late: assert property (calc_armed |-> calc_cnt <= CALC_MAX)
        else $error("slew started too late");
    chk_apply_rail1: assert property ($changed(rail1_setpoint) |-> rail1_slew_start)
        else $error("rail 1 setpoint moved without slew");
    chk_apply_rail2: assert property ($changed(rail2_setpoint) |-> rail2_slew_start)
        else $error("rail 2 setpoint moved without slew");
    chk_slew_pulse: assert property (rail1_slew_start |=> !rail1_slew_start)
        else $error("slew start longer than a cycle");
    chk_sync_delay: assert property (slew6 |-> calc_cnt >= SYNC_MIN)
        else $error("select edge acted on before synchroniser");
    cov_six_rise: cover property (rise6);
    cov_rail2_cmd: cover property (cmd_valid && cmd_code == 8'hbd);
    cov_rail2_slew: cover property (rail2_slew_start);
endmodule : vcsr_asserts

// File: verification/tb_voltage_code_setpoint_receiver.sv
// Bench joining host and receiver ends across the code link
`timescale 1ns/10ps
module tb_voltage_code_setpoint_receiver
    import vcsr_pkg::*;
;
    logic clk_sys;
    logic rst_n;
    logic req_valid;
    logic req_rail;
    vcsr_code_t req_code;
    logic [1:0] req_fmt;
    logic cfg_valid;
    logic [39:0] cfg_data;
    logic req_ready;
    vcsr_mv_t rail1_setpoint;
    vcsr_mv_t rail2_setpoint;
    logic rail1_slew_start;
    logic rail2_slew_start;
    logic [1:0] code_width_setting;
    logic [1:0] seen;
    int errors;
    int checked;
    vcsr_link_if link();
    vcsr_host i_vcsr_host(.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid),
        .req_rail(req_rail), .req_code(req_code), .req_fmt(req_fmt), .cfg_valid(cfg_valid),
        .cfg_data(cfg_data), .req_ready(req_ready), .link(link));
    vcsr_device i_vcsr_device(.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
        .rail1_setpoint(rail1_setpoint), .rail2_setpoint(rail2_setpoint),
        .rail1_slew_start(rail1_slew_start), .rail2_slew_start(rail2_slew_start),
        .code_width_setting(code_width_setting));
    vcsr_asserts i_vcsr_asserts(.clk_sys(clk_sys), .rst_n(rst_n), .line_a(link.line_a),
        .line_b(link.line_b), .line_c(link.line_c), .select_strobe(link.select_strobe),
        .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code),
        .rail1_setpoint(rail1_setpoint), .rail2_setpoint(rail2_setpoint),
        .rail1_slew_start(rail1_slew_start), .rail2_slew_start(rail2_slew_start),
        .code_width_setting(code_width_setting));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic finish_test;
        if (errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, got, exp);
        end
    endtask : check
    function automatic vcsr_mv_t exp_mv(input int lo, input int hi, input int w, input int code);
        return vcsr_mv_t'(lo + code * (hi - lo) / ((1 << w) - 1));
    endfunction : exp_mv
    // A hung host ends the run rather than the whole simulation stalling
    task automatic wait_ready;
        int i;
        i = 0;
        while (req_ready !== 1'b1 && i < 40000) begin
            @(negedge clk_sys);
            i++;
        end
        if (req_ready !== 1'b1) begin
            errors++;
            finish_test();
        end
    endtask : wait_ready
    task automatic send_cfg(input logic [1:0] fmt, input vcsr_code_t boot, input int lo,
        input int hi);
        wait_ready();
        cfg_data = {hi[15:0], lo[15:0], boot[7:2], fmt};
        cfg_valid = 1'b1;
        @(negedge clk_sys);
        cfg_valid = 1'b0;
        repeat (4500) @(negedge clk_sys);
    endtask : send_cfg
    task automatic send_code(input logic rail, input vcsr_code_t code, input logic [1:0] fmt);
        wait_ready();
        req_rail = rail;
        req_code = code;
        req_fmt = fmt;
        req_valid = 1'b1;
        @(negedge clk_sys);
        req_valid = 1'b0;
    endtask : send_code
    // Want of zero watches the full span for a pulse that must not come
    task automatic watch(input int n, input logic [1:0] want);
        int i;
        i = 0;
        seen = 2'b00;
        while (i < n && (want == 2'b00 || seen != want)) begin
            @(negedge clk_sys);
            seen = seen | {rail2_slew_start, rail1_slew_start};
            i++;
        end
        if (want != 2'b00 && seen != want) begin
            errors++;
            finish_test();
        end
    endtask : watch
    task automatic wait_line(input logic lvl, input logic [2:0] exp);
        int i;
        i = 0;
        while (link.select_strobe[0] !== lvl && i < 20000) begin
            @(negedge clk_sys);
            i++;
        end
        if (link.select_strobe[0] !== lvl) begin
            errors++;
            finish_test();
        end
        check({link.line_c[0], link.line_b[0], link.line_a[0]}, exp);
    endtask : wait_line
    task automatic t_boot;
        watch(5000, 2'b11);
        check(seen, 2'b11);
        check(code_width_setting, 2'h0);
    endtask : t_boot
    task automatic t_eight;
        send_cfg(2'h2, 8'h06, 500, 1520);
        check(code_width_setting, 2'h2);
        check(rail1_setpoint, exp_mv(500, 1520, 8, 6));
        check(rail2_setpoint, exp_mv(500, 1520, 8, 6));
        send_code(1'b0, 8'hc8, 2'h2);
        watch(5000, 2'b01);
        check(seen, 2'b01);
        check(rail1_setpoint, exp_mv(500, 1520, 8, 200));
        send_code(1'b1, 8'hff, 2'h2);
        watch(5000, 2'b10);
        check(seen, 2'b10);
        check(rail2_setpoint, exp_mv(500, 1520, 8, 255));
        check(rail1_setpoint, exp_mv(500, 1520, 8, 200));
        send_code(1'b1, 8'hff, 2'h2);
        watch(4500, 2'b00);
        check(seen, 2'b00);
    endtask : t_eight
    task automatic t_six;
        send_cfg(2'h1, 8'h01, 600, 1230);
        check(code_width_setting, 2'h1);
        check(rail1_setpoint, exp_mv(600, 1230, 6, 1));
        send_code(1'b0, 8'h2a, 2'h1);
        wait_line(1'b0, 3'b010);
        wait_line(1'b1, 3'b101);
        watch(20000, 2'b01);
        check(seen, 2'b01);
        check(rail1_setpoint, exp_mv(600, 1230, 6, 42));
        send_code(1'b0, 8'h33, 2'h2);
        watch(4500, 2'b00);
        check(seen, 2'b00);
        check(rail1_setpoint, exp_mv(600, 1230, 6, 42));
        send_code(1'b1, 8'h3f, 2'h1);
        watch(40000, 2'b10);
        check(seen, 2'b10);
        check(rail2_setpoint, exp_mv(600, 1230, 6, 63));
    endtask : t_six
    initial begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        req_rail = 1'b0;
        req_code = 8'h00;
        req_fmt = 2'h0;
        cfg_valid = 1'b0;
        cfg_data = 40'h0;
        errors = 0;
        checked = 0;
        repeat (8) @(negedge clk_sys);
        rst_n = 1'b1;
        t_boot();
        t_eight();
        t_six();
        finish_test();
    end
endmodule : tb_voltage_code_setpoint_receiver
